// >>> rtl/exec_slice.sv
/*
 * Execution slice of an 8-bit accumulator CPU: compare-branch-unequal,
 * zero and invert of accumulator, carry or bit, decimal adjust, count
 * down, count-down-branch and unsigned divide.
 * Assumes the fetch pipeline hands over the opcode, the following bytes,
 * the instruction address and the operand values (working register,
 * pointed RAM byte or direct byte from pins, plus the port output latch
 * and port flag for direct addresses) in the start cycle, and that it
 * performs the writes this slice requests in the done cycle.
 */
// Contract
// - Compare-branch-unequal branches only when the two operands differ.
// - Compare sets carry when destination below source, else clears; operands untouched.
// - Compare forms: A/direct, A/immediate, working register/immediate, pointed RAM/immediate.
// - Compare is three bytes, two cycles; PC advances three before branch.
// - Zero accumulator clears A, no flag change, one byte one cycle.
// - Zero carry (one byte) or addressable bit (two bytes), one cycle each.
// - Invert accumulator gives one's complement, flags unchanged, one byte one cycle.
// - Invert carry (one byte) or addressable bit (two bytes), one cycle.
// - Port read-modify-write takes the output latch, not the pin levels.
// - Decimal adjust adds six when low nibble above nine or nibble carry set.
// - Then adds six to high nibble when carry set or nibble above nine.
// - Decimal adjust is one cycle, only sets carry, never touches overflow.
// - Count down subtracts one with wrap from A, register, direct or pointed byte.
// - Divide gives quotient in A, remainder in B, clears carry and overflow, four cycles.
// - Zero divisor sets overflow and clears carry.
// - Count-down-branch wraps, branches on nonzero result, flags unchanged.
// - Count-down-branch register form two bytes, direct form three, both two cycles.
// - Branch target is next-instruction address plus sign-extended last byte.
module exec_slice
   import exec_slice_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [7:0] opcode,
   input wire logic [7:0] byte2,
   input wire logic [7:0] byte3,
   input wire logic [15:0] pc_in,
   input wire logic [7:0] acc_in,
   input wire logic [7:0] b_in,
   input wire logic carry_in,
   input wire logic nibble_carry_in,
   input wire logic [7:0] operand_in,
   input wire logic [7:0] latch_in,
   input wire logic port_hit,
   input wire logic bit_pin_in,
   input wire logic bit_latch_in,
   output logic busy,
   output logic done,
   output logic [15:0] pc_next,
   output logic [7:0] acc_out,
   output logic acc_we,
   output logic [7:0] b_out,
   output logic b_we,
   output logic carry_out,
   output logic carry_we,
   output logic wf_out,
   output logic wf_we,
   output logic [7:0] mem_wdata,
   output logic mem_we,
   output logic bit_wdata,
   output logic bit_we
);

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------

   // Opcode to operation class; anything outside this slice is OP_NONE
   function automatic op_class_t op_class(input logic [7:0] opc);
      op_class = OP_NONE;
      if (opc == OPC_CMP_A_IMM || opc == OPC_CMP_A_DIR || opc[7:1] == OPC_CMP_IND[7:1]
          || opc[7:3] == OPC_CMP_REG[7:3]) begin
         op_class = OP_CMP;
      end else if (opc == OPC_ZERO_A) begin
         op_class = OP_ZERO_A;
      end else if (opc == OPC_ZERO_C) begin
         op_class = OP_ZERO_C;
      end else if (opc == OPC_ZERO_BIT) begin
         op_class = OP_ZERO_BIT;
      end else if (opc == OPC_INV_A) begin
         op_class = OP_INV_A;
      end else if (opc == OPC_INV_C) begin
         op_class = OP_INV_C;
      end else if (opc == OPC_INV_BIT) begin
         op_class = OP_INV_BIT;
      end else if (opc == OPC_BCD) begin
         op_class = OP_BCD;
      end else if (opc == OPC_DN_A) begin
         op_class = OP_DN_A;
      end else if (opc == OPC_DN_DIR || opc[7:1] == OPC_DN_IND[7:1]
                   || opc[7:3] == OPC_DN_REG[7:3]) begin
         op_class = OP_DN_MEM;
      end else if (opc == OPC_DIVIDE) begin
         op_class = OP_DIVIDE;
      end else if (opc == OPC_DNB_DIR || opc[7:3] == OPC_DNB_REG[7:3]) begin
         op_class = OP_DNB;
      end
   endfunction : op_class

   // Instruction length in bytes
   function automatic logic [15:0] op_len(input logic [7:0] opc);
      unique case (op_class(opc))
         OP_CMP: op_len = LEN_THREE;
         OP_ZERO_BIT, OP_INV_BIT: op_len = LEN_TWO;
         OP_DN_MEM: op_len = (opc == OPC_DN_DIR) ? LEN_TWO : LEN_ONE;
         OP_DNB: op_len = (opc == OPC_DNB_DIR) ? LEN_THREE : LEN_TWO;
         default: op_len = LEN_ONE;
      endcase
   endfunction : op_len

   // Machine cycles the instruction occupies
   function automatic logic [2:0] op_cycles(input op_class_t cls);
      unique case (cls)
         OP_CMP, OP_DNB: op_cycles = CYC_TWO;
         OP_DIVIDE: op_cycles = CYC_DIV;
         default: op_cycles = CYC_ONE;
      endcase
   endfunction : op_cycles

   // Direct address forms that may land on a port latch
   function automatic logic is_direct_rmw(input logic [7:0] opc);
      is_direct_rmw = (opc == OPC_DN_DIR) || (opc == OPC_DNB_DIR);
   endfunction : is_direct_rmw

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      exec_state_t st;
      logic [1:0] cnt;
      logic is_div;
      logic [5:0] pend;   // acc, b, carry, wrap, mem, bit
      logic [15:0] pc;
      logic [7:0] acc;
      logic [7:0] b;
      logic cy;
      logic wf;
      logic [7:0] mem;
      logic bitv;
      logic [5:0] we;
      logic done;
   } core_state_t;

   core_state_t cur_q;
   core_state_t cur_d;

   logic [7:0] bcd_acc;
   logic bcd_carry;
   logic [7:0] div_quo;
   logic [7:0] div_rem;
   logic div_start;

   bcd_fixup_unit u_bcd (
      .acc_in(acc_in),
      .carry_in(carry_in),
      .nibble_carry_in(nibble_carry_in),
      .acc_out(bcd_acc),
      .carry_out(bcd_carry)
   );

   byte_divider u_div (
      .core_clk(core_clk),
      .rst(rst),
      .start(div_start),
      .dividend(acc_in),
      .divisor(b_in),
      .quotient(div_quo),
      .remainder(div_rem)
   );

   // A start during a running instruction is ignored
   assign div_start = start && (cur_q.st == ST_IDLE) && (op_class(opcode) == OP_DIVIDE);

   // ----------------------------------------------------------------
   // Execute: results are formed at take (divide quotient and remainder at the last run edge), released at done
   // ----------------------------------------------------------------
   always_comb begin
      op_class_t cls;
      logic [7:0] dst;
      logic [7:0] src;
      logic [7:0] rel;
      logic [7:0] rmw;
      logic [7:0] dn_val;
      logic bit_src;
      logic [15:0] seq_pc;
      logic [2:0] cycles;
      cur_d = cur_q;
      cls = op_class(opcode);
      dst = (opcode == OPC_CMP_A_IMM || opcode == OPC_CMP_A_DIR) ? acc_in : operand_in;
      src = (opcode == OPC_CMP_A_DIR) ? operand_in : byte2;
      rel = (cls == OP_DNB && opcode != OPC_DNB_DIR) ? byte2 : byte3;
      rmw = (is_direct_rmw(opcode) && port_hit) ? latch_in : operand_in;
      bit_src = port_hit ? bit_latch_in : bit_pin_in;
      dn_val = rmw - 8'h01;
      seq_pc = pc_in + op_len(opcode);
      cycles = op_cycles(cls);
      cur_d.done = 1'b0;
      cur_d.we = 6'h00;
      unique case (cur_q.st)
         ST_IDLE: begin
            if (start && cls != OP_NONE) begin
               cur_d.st = ST_RUN;
               cur_d.cnt = 2'(cycles - 3'h1);
               cur_d.is_div = (cls == OP_DIVIDE);
               cur_d.pc = seq_pc;
               cur_d.pend = 6'h00;
               unique case (cls)
                  OP_CMP: begin
                     if (dst != src) begin
                        cur_d.pc = seq_pc + {{8{rel[7]}}, rel};
                     end
                     cur_d.cy = (dst < src);
                     cur_d.pend = 6'b001000;
                  end
                  OP_ZERO_A: begin
                     cur_d.acc = 8'h00;
                     cur_d.pend = 6'b100000;
                  end
                  OP_ZERO_C: begin
                     cur_d.cy = 1'b0;
                     cur_d.pend = 6'b001000;
                  end
                  OP_ZERO_BIT: begin
                     cur_d.bitv = 1'b0;
                     cur_d.pend = 6'b000001;
                  end
                  OP_INV_A: begin
                     cur_d.acc = ~acc_in;
                     cur_d.pend = 6'b100000;
                  end
                  OP_INV_C: begin
                     cur_d.cy = ~carry_in;
                     cur_d.pend = 6'b001000;
                  end
                  OP_INV_BIT: begin
                     cur_d.bitv = ~bit_src;
                     cur_d.pend = 6'b000001;
                  end
                  OP_BCD: begin
                     cur_d.acc = bcd_acc;
                     cur_d.cy = bcd_carry;
                     cur_d.pend = 6'b101000;
                  end
                  OP_DN_A: begin
                     cur_d.acc = acc_in - 8'h01;
                     cur_d.pend = 6'b100000;
                  end
                  OP_DN_MEM: begin
                     cur_d.mem = dn_val;
                     cur_d.pend = 6'b000010;
                  end
                  OP_DIVIDE: begin
                     cur_d.cy = 1'b0;
                     cur_d.wf = (b_in == 8'h00);
                     cur_d.pend = 6'b111100;
                  end
                  OP_DNB: begin
                     cur_d.mem = dn_val;
                     if (dn_val != 8'h00) begin
                        cur_d.pc = seq_pc + {{8{rel[7]}}, rel};
                     end
                     cur_d.pend = 6'b000010;
                  end
                  default: begin
                     cur_d.pend = 6'h00;
                  end
               endcase
            end
         end
         ST_RUN: begin
            if (cur_q.cnt == 2'h0) begin
               // Divider results are stable by the fourth edge
               if (cur_q.is_div) begin
                  cur_d.acc = div_quo;
                  cur_d.b = div_rem;
               end
               cur_d.st = ST_IDLE;
               cur_d.we = cur_q.pend;
               cur_d.done = 1'b1;
            end else begin
               cur_d.cnt = cur_q.cnt - 2'h1;
            end
         end
      endcase
   end

   // ----------------------------------------------------------------
   // State register
   // ----------------------------------------------------------------
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cur_q <= '0;
      end else begin
         cur_q <= cur_d;
      end
   end

   // Outputs straight from the state flops
   assign busy = cur_q.st[0];
   assign done = cur_q.done;
   assign pc_next = cur_q.pc;
   assign acc_out = cur_q.acc;
   assign b_out = cur_q.b;
   assign carry_out = cur_q.cy;
   assign wf_out = cur_q.wf;
   assign mem_wdata = cur_q.mem;
   assign bit_wdata = cur_q.bitv;
   assign acc_we = cur_q.we[5];
   assign b_we = cur_q.we[4];
   assign carry_we = cur_q.we[3];
   assign wf_we = cur_q.we[2];
   assign mem_we = cur_q.we[1];
   assign bit_we = cur_q.we[0];

endmodule : exec_slice

// >>> rtl/exec_slice_pkg.sv
/*
 * Shared constants for the compare, clear, invert, decimal-adjust,
 * count-down and divide execution slice: opcodes, lengths, cycle counts.
 * Assumes one machine cycle of the slice equals one core_clk period.
 */
package exec_slice_pkg;

   // ----------------------------------------------------------------
   // Opcodes handled by this slice
   // ----------------------------------------------------------------
   localparam logic [7:0] OPC_CMP_A_IMM = 8'hB4;
   localparam logic [7:0] OPC_CMP_A_DIR = 8'hB5;
   localparam logic [7:0] OPC_CMP_IND = 8'hB6;   // Low bit picks the pointer register
   localparam logic [7:0] OPC_CMP_REG = 8'hB8;   // Low three bits pick the working register
   localparam logic [7:0] OPC_ZERO_A = 8'hE4;
   localparam logic [7:0] OPC_ZERO_C = 8'hC3;
   localparam logic [7:0] OPC_ZERO_BIT = 8'hC2;
   localparam logic [7:0] OPC_INV_A = 8'hF4;
   localparam logic [7:0] OPC_INV_C = 8'hB3;
   localparam logic [7:0] OPC_INV_BIT = 8'hB2;
   localparam logic [7:0] OPC_BCD = 8'hD4;
   localparam logic [7:0] OPC_DN_A = 8'h14;
   localparam logic [7:0] OPC_DN_DIR = 8'h15;
   localparam logic [7:0] OPC_DN_IND = 8'h16;
   localparam logic [7:0] OPC_DN_REG = 8'h18;
   localparam logic [7:0] OPC_DIVIDE = 8'h84;
   localparam logic [7:0] OPC_DNB_REG = 8'hD8;
   localparam logic [7:0] OPC_DNB_DIR = 8'hD5;

   // ----------------------------------------------------------------
   // Instruction lengths in bytes and machine cycles
   // ----------------------------------------------------------------
   localparam logic [15:0] LEN_ONE = 16'h0001;
   localparam logic [15:0] LEN_TWO = 16'h0002;
   localparam logic [15:0] LEN_THREE = 16'h0003;
   localparam logic [2:0] CYC_ONE = 3'h1;
   localparam logic [2:0] CYC_TWO = 3'h2;
   localparam logic [2:0] CYC_DIV = 3'h4;

   // ----------------------------------------------------------------
   // Decimal adjust constants
   // ----------------------------------------------------------------
   localparam logic [3:0] BCD_DIGIT_MAX = 4'h9;
   localparam logic [3:0] BCD_FIX = 4'h6;

   // Divide steps: two quotient bits per machine cycle over four cycles
   localparam logic [1:0] DIV_LAST_STEP = 2'h3;

   // Operation classes after decode
   typedef enum logic [3:0] {
      OP_NONE = 4'h0,
      OP_CMP = 4'h1,
      OP_ZERO_A = 4'h2,
      OP_ZERO_C = 4'h3,
      OP_ZERO_BIT = 4'h4,
      OP_INV_A = 4'h5,
      OP_INV_C = 4'h6,
      OP_INV_BIT = 4'h7,
      OP_BCD = 4'h8,
      OP_DN_A = 4'h9,
      OP_DN_MEM = 4'hA,
      OP_DIVIDE = 4'hB,
      OP_DNB = 4'hC
   } op_class_t;

   // Control states, Gray along idle -> run
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_RUN = 2'b01
   } exec_state_t;

endpackage : exec_slice_pkg

// >>> rtl/bcd_fixup_unit.sv
/*
 * Combinational decimal-adjust datapath for the accumulator after a
 * packed-BCD addition. Assumes the caller applies the result at once.
 */
module bcd_fixup_unit
   import exec_slice_pkg::*;
(
   input wire logic [7:0] acc_in,
   input wire logic carry_in,
   input wire logic nibble_carry_in,
   output logic [7:0] acc_out,
   output logic carry_out
);

   // ----------------------------------------------------------------
   // Two-step correction; net effect is adding 00, 06, 60 or 66 hex
   // ----------------------------------------------------------------
   always_comb begin
      logic [8:0] low_sum;
      logic [8:0] high_sum;
      logic cy_mid;
      low_sum = {1'b0, acc_in};
      if ((acc_in[3:0] > BCD_DIGIT_MAX) || nibble_carry_in) begin
         low_sum = {1'b0, acc_in} + {5'h00, BCD_FIX};
      end
      cy_mid = carry_in | low_sum[8];
      high_sum = {1'b0, low_sum[7:0]};
      if (cy_mid || (low_sum[7:4] > BCD_DIGIT_MAX)) begin
         high_sum = {1'b0, low_sum[7:0]} + {1'b0, BCD_FIX, 4'h0};
      end
      acc_out = high_sum[7:0];
      carry_out = cy_mid | high_sum[8];
   end

endmodule : bcd_fixup_unit

// >>> rtl/byte_divider.sv
/*
 * Unsigned 8-bit by 8-bit restoring divider, two quotient bits per clock.
 * Assumes start is a one-cycle pulse with operands valid in that cycle;
 * results are valid from the third edge after the start edge.
 */
module byte_divider
   import exec_slice_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [7:0] dividend,
   input wire logic [7:0] divisor,
   output logic [7:0] quotient,
   output logic [7:0] remainder
);

   typedef struct packed {
      logic [7:0] rem;
      logic [7:0] quo;
      logic [7:0] dvs;
      logic [1:0] step;
      logic active;
   } div_state_t;

   div_state_t cur_q;
   div_state_t cur_d;

   // One shift-subtract step; a zero divisor always subtracts, which
   // leaves all ones in the quotient and the dividend as remainder
   function automatic logic [15:0] div_step(input logic [7:0] rem, input logic [7:0] quo,
                                            input logic [7:0] dvs);
      logic [8:0] part;
      logic take;
      part = {rem, quo[7]};
      take = (part >= {1'b0, dvs});
      if (take) begin
         part = part - {1'b0, dvs};
      end
      div_step = {part[7:0], quo[6:0], take};
   endfunction : div_step

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      logic [15:0] s1;
      logic [15:0] s2;
      cur_d = cur_q;
      s1 = 16'h0000;
      s2 = 16'h0000;
      if (start) begin
         s1 = div_step(8'h00, dividend, divisor);
         s2 = div_step(s1[15:8], s1[7:0], divisor);
         cur_d.rem = s2[15:8];
         cur_d.quo = s2[7:0];
         cur_d.dvs = divisor;
         cur_d.step = 2'h1;
         cur_d.active = 1'b1;
      end else if (cur_q.active) begin
         s1 = div_step(cur_q.rem, cur_q.quo, cur_q.dvs);
         s2 = div_step(s1[15:8], s1[7:0], cur_q.dvs);
         cur_d.rem = s2[15:8];
         cur_d.quo = s2[7:0];
         cur_d.step = cur_q.step + 2'h1;
         cur_d.active = (cur_q.step != DIV_LAST_STEP);
      end
   end

   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         cur_q <= '0;
      end else begin
         cur_q <= cur_d;
      end
   end

   assign quotient = cur_q.quo;
   assign remainder = cur_q.rem;

endmodule : byte_divider

// >>> testbench/exec_slice_chk.sv
/*
 * Timing and result checker for the execution slice.
 * Assumes it is bound to exec_slice and sees its ports only.
 */
module exec_slice_chk
   import exec_slice_pkg::*;
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic start,
   input wire logic [7:0] opcode,
   input wire logic [7:0] byte2,
   input wire logic [7:0] byte3,
   input wire logic [15:0] pc_in,
   input wire logic [7:0] acc_in,
   input wire logic [7:0] b_in,
   input wire logic carry_in,
   input wire logic busy,
   input wire logic done,
   input wire logic [15:0] pc_next,
   input wire logic [7:0] acc_out,
   input wire logic acc_we,
   input wire logic b_we,
   input wire logic carry_out,
   input wire logic carry_we,
   input wire logic wf_out,
   input wire logic wf_we
);
   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   // ---------------------------------------------------------------
   // Expected compare target, computed every edge
   // ---------------------------------------------------------------
   logic [15:0] tgt_q;

   // Sampled at the take edge so the assertion needs no nested $past
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         tgt_q <= 16'h0000;
      end else begin
         tgt_q <= pc_in + 16'h0003 + ((acc_in != byte2) ? {{8{byte3[7]}}, byte3} : 16'h0000);
      end
   end

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   chk_zero_acc: assert property (start && !busy && opcode == OPC_ZERO_A |=>
      busy && acc_out == 8'h00 ##1 done && acc_we && !busy && !carry_we && !wf_we)
      else $error("zero accumulator result or timing wrong");
   chk_invert_acc: assert property (start && !busy && opcode == OPC_INV_A |=>
      acc_out == ~$past(acc_in) ##1 done && acc_we && !carry_we)
      else $error("invert accumulator result wrong");
   chk_cmp_carry: assert property (start && !busy && opcode == OPC_CMP_A_IMM |=>
      carry_out == ($past(acc_in) < $past(byte2)) ##1 !done ##1 done && carry_we && !acc_we)
      else $error("compare carry or timing wrong");
   chk_cmp_target: assert property (start && !busy && opcode == OPC_CMP_A_IMM |=>
      pc_next == tgt_q)
      else $error("compare branch target wrong");
   chk_div_timing: assert property (start && !busy && opcode == OPC_DIVIDE |=>
      !done [*4] ##1 done && acc_we && b_we && carry_we && wf_we && !carry_out)
      else $error("divide timing or flags wrong");
   chk_div_zero: assert property (start && !busy && opcode == OPC_DIVIDE && b_in == 8'h00
      |-> ##5 wf_out && !carry_out)
      else $error("divide by zero flags wrong");
   chk_dn_acc: assert property (start && !busy && opcode == OPC_DN_A |=>
      acc_out == $past(acc_in) - 8'h01 ##1 done && acc_we && !carry_we && !wf_we)
      else $error("count down accumulator wrong");
   chk_bcd_keep: assert property (start && !busy && opcode == OPC_BCD && carry_in |->
      ##2 done && carry_out && !wf_we)
      else $error("decimal adjust cleared carry or wrote overflow");
endmodule : exec_slice_chk

bind exec_slice exec_slice_chk chk_i (.core_clk(core_clk), .rst(rst), .start(start),
   .opcode(opcode), .byte2(byte2), .byte3(byte3), .pc_in(pc_in), .acc_in(acc_in),
   .b_in(b_in), .carry_in(carry_in), .busy(busy), .done(done), .pc_next(pc_next),
   .acc_out(acc_out), .acc_we(acc_we), .b_we(b_we), .carry_out(carry_out),
   .carry_we(carry_we), .wf_out(wf_out), .wf_we(wf_we));

// >>> testbench/exec_slice_test.sv
/*
 * Self-checking bench for the execution slice, one task per scenario.
 * Assumes the slice and its package are compiled before this file.
 */
`define CHK(nm, e, g) begin \
   total_checks++; \
   if ((g) !== (e)) begin \
      n_fail++; \
      $display("[FAIL] %s expected %h seen %h", nm, e, g); \
   end \
end

module exec_slice_test
   import exec_slice_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;

   logic core_clk = 1'b0;
   logic rst = 1'b1;
   logic start, port_hit, bit_pin_in, bit_latch_in, carry_in, nibble_carry_in;
   logic [7:0] opcode, byte2, byte3, acc_in, b_in, operand_in, latch_in;
   logic [15:0] pc_in, pc_next;
   logic busy, done, acc_we, b_we, carry_out, carry_we, wf_out, wf_we;
   logic bit_wdata, bit_we, mem_we;
   logic [7:0] acc_out, b_out, mem_wdata;
   logic [7:0] v_acc, v_b, v_opnd, v_latch, v_got;
   logic v_c, v_nc, v_hit, v_pin, v_bl;
   logic [15:0] v_pc;
   int n_fail = 0;
   int total_checks = 0;
   localparam logic [7:0] ONE_OPS [6] = '{OPC_ZERO_A, OPC_INV_A, OPC_ZERO_C, OPC_INV_C,
      OPC_ZERO_BIT, OPC_INV_BIT};
   localparam logic [7:0] CMP_OPS [4] = '{OPC_CMP_A_IMM, OPC_CMP_A_DIR, 8'hBF, 8'hB7};
   localparam logic [7:0] BCD_IN [4] = '{8'hBE, 8'hC9, 8'h0A, 8'h12};
   localparam logic [7:0] BCD_OUT [4] = '{8'h24, 8'h29, 8'h10, 8'h78};
   localparam logic [7:0] DN_OPS [6] = '{OPC_DN_A, 8'h1B, OPC_DN_DIR, 8'h17, 8'hDA, OPC_DNB_DIR};
   localparam logic [7:0] DN_IN [6] = '{8'h00, 8'h00, 8'h55, 8'h80, 8'h01, 8'h00};
   localparam logic [7:0] DN_OUT [6] = '{8'hFF, 8'hFF, 8'h0F, 8'h7F, 8'h00, 8'h6F};
   localparam logic [15:0] DN_LEN [6] = '{16'h1, 16'h1, 16'h2, 16'h1, 16'h2, 16'h13};

   exec_slice dut (.core_clk(core_clk), .rst(rst), .start(start), .opcode(opcode),
      .byte2(byte2), .byte3(byte3), .pc_in(pc_in), .acc_in(acc_in), .b_in(b_in),
      .carry_in(carry_in), .nibble_carry_in(nibble_carry_in), .operand_in(operand_in),
      .latch_in(latch_in), .port_hit(port_hit), .bit_pin_in(bit_pin_in),
      .bit_latch_in(bit_latch_in), .busy(busy), .done(done), .pc_next(pc_next),
      .acc_out(acc_out), .acc_we(acc_we), .b_out(b_out), .b_we(b_we),
      .carry_out(carry_out), .carry_we(carry_we), .wf_out(wf_out), .wf_we(wf_we),
      .mem_wdata(mem_wdata), .mem_we(mem_we), .bit_wdata(bit_wdata), .bit_we(bit_we));

   // 100 ns period
   always #50 core_clk = ~core_clk;

   // ---------------------------------------------------------------
   // Shared tasks
   // ---------------------------------------------------------------
   task automatic stop_test();
      if (n_fail == 0 && total_checks > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : stop_test

   // One instruction; returns in the done cycle with outputs settled
   task automatic run(input logic [7:0] op, input logic [7:0] b2, input logic [7:0] b3,
      input int cyc);
      int n;
      @(posedge core_clk);
      start <= 1'b1;
      opcode <= op;
      byte2 <= b2;
      byte3 <= b3;
      pc_in <= v_pc;
      acc_in <= v_acc;
      b_in <= v_b;
      carry_in <= v_c;
      nibble_carry_in <= v_nc;
      operand_in <= v_opnd;
      latch_in <= v_latch;
      port_hit <= v_hit;
      bit_pin_in <= v_pin;
      bit_latch_in <= v_bl;
      @(posedge core_clk);
      start <= 1'b0;
      #1;
      n = 0;
      // Bounded wait: a missing done must not hang the run
      while (done !== 1'b1 && n < 10) begin
         @(posedge core_clk);
         #1;
         n++;
      end
      if (n == 10) begin
         n_fail++;
         stop_test();
      end
      `CHK("latency", cyc, n)
   endtask : run

   // ---------------------------------------------------------------
   // Scenarios
   // ---------------------------------------------------------------
   // Carry starts at one so zeroing it is visible; pin and latch differ
   task automatic t_zero_invert();
      v_acc = 8'h5C;
      v_c = 1'b1;
      v_hit = 1'b1;
      v_pin = 1'b0;
      v_bl = 1'b1;
      v_pc = 16'h0100;
      for (int i = 0; i < 6; i++) begin
         run(ONE_OPS[i], 8'h20, 8'h00, 1);
         `CHK("one_pc", v_pc + ((i > 3) ? 16'h0002 : 16'h0001), pc_next)
         `CHK("one_we", {i < 2, i / 2 == 1, i > 3, 1'b0}, {acc_we, carry_we, bit_we, wf_we})
         v_got = (i < 2) ? acc_out : 8'((i < 4) ? carry_out : bit_wdata);
         `CHK("one_val", (i == 1) ? 8'hA3 : 8'h00, v_got)
      end
   endtask : t_zero_invert

   // All four forms; wrap of the program counter past FFFF
   task automatic t_compare();
      logic [7:0] b2, dst, src;
      v_pc = 16'hFFFE;
      v_acc = 8'h34;
      for (int i = 0; i < 4; i++) begin
         v_opnd = (i == 1) ? 8'h34 : (i == 2) ? 8'h56 : 8'h80;
         b2 = (i == 1) ? 8'h90 : (i == 3) ? 8'h7F : 8'h60;
         dst = (i < 2) ? v_acc : v_opnd;
         src = (i == 1) ? v_opnd : b2;
         run(CMP_OPS[i], b2, 8'hF0, 2);
         `CHK("cmp_pc", v_pc + 16'h0003 + ((dst != src) ? 16'hFFF0 : 16'h0), pc_next)
         `CHK("cmp_carry", dst < src, carry_out)
         `CHK("cmp_we", 3'b100, {carry_we, acc_we, mem_we})
      end
   endtask : t_compare

   task automatic t_bcd();
      for (int i = 0; i < 4; i++) begin
         v_acc = BCD_IN[i];
         v_c = (i == 3);
         v_nc = (i == 3);
         run(OPC_BCD, 8'h00, 8'h00, 1);
         `CHK("bcd_acc", BCD_OUT[i], acc_out)
         `CHK("bcd_carry", i != 2, carry_out)
         `CHK("bcd_wf_we", 1'b0, wf_we)
      end
   endtask : t_bcd

   // Port forms differ between latch and pins to expose the source
   task automatic t_count_down();
      v_acc = 8'h00;
      v_pc = 16'h0200;
      for (int i = 0; i < 6; i++) begin
         v_opnd = DN_IN[i];
         v_latch = (i == 2) ? 8'h10 : 8'h70;
         v_hit = (i == 2 || i == 5);
         run(DN_OPS[i], 8'h10, 8'h10, (i > 3) ? 2 : 1);
         `CHK("dn_pc", v_pc + DN_LEN[i], pc_next)
         `CHK("dn_val", DN_OUT[i], (i == 0) ? acc_out : mem_wdata)
         `CHK("dn_we", (i == 0) ? 3'b100 : 3'b010, {acc_we, mem_we, carry_we})
      end
   endtask : t_count_down

   task automatic t_divide();
      v_c = 1'b1;
      for (int i = 0; i < 2; i++) begin
         v_acc = i ? 8'h5A : 8'hFB;
         v_b = i ? 8'h00 : 8'h12;
         run(OPC_DIVIDE, 8'h00, 8'h00, 4);
         `CHK("div_acc", i ? 8'hFF : 8'h0D, acc_out)
         `CHK("div_b", i ? 8'h5A : 8'h11, b_out)
         `CHK("div_flags", {1'b0, i[0]}, {carry_out, wf_out})
         `CHK("div_we", 4'hF, {acc_we, b_we, carry_we, wf_we})
      end
   endtask : t_divide

   // ---------------------------------------------------------------
   // Main sequence
   // ---------------------------------------------------------------
   initial begin
      {start, port_hit, bit_pin_in, bit_latch_in, carry_in, nibble_carry_in} = '0;
      {opcode, byte2, byte3, acc_in, b_in, operand_in, latch_in, pc_in} = '0;
      {v_acc, v_b, v_opnd, v_latch, v_c, v_nc, v_hit, v_pin, v_bl, v_pc} = '0;
      repeat (5) @(posedge core_clk);
      rst <= 1'b0;
      t_zero_invert();
      t_compare();
      t_bcd();
      t_count_down();
      t_divide();
      stop_test();
   end
endmodule : exec_slice_test
